//--- logic/alx_map.svh
// Purpose: Register offsets, opcodes, field positions and reset values
// Assumes: AXI4-Lite byte addresses, 32-bit data
// Notes:   Definitions only
`ifndef ALX_MAP_SVH
`define ALX_MAP_SVH

// ----------------------------------------------------------------
// Bus width and response codes
// ----------------------------------------------------------------
`define ALX_ADDR_W        8
`define ALX_RESP_OKAY     2'h0
`define ALX_RESP_SLVERR   2'h2

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ALX_OFF_INSTR     8'h00
`define ALX_OFF_ACC       8'h04
`define ALX_OFF_XREG      8'h08
`define ALX_OFF_PTR       8'h0C
`define ALX_OFF_IRQ       8'h10
`define ALX_OFF_WAKE_A    8'h14
`define ALX_OFF_WAKE_B    8'h18
`define ALX_OFF_WAKE_C    8'h1C
`define ALX_OFF_WAKE_D    8'h20
`define ALX_OFF_LCD       8'h24
`define ALX_OFF_DATA_PTR  8'h28
`define ALX_OFF_RAM       8'h2C
`define ALX_OFF_STATUS    8'h30

// ----------------------------------------------------------------
// Opcodes and immediate field
// ----------------------------------------------------------------
`define ALX_OP_W          10
`define ALX_OP_PTR        10'h051
`define ALX_OP_IRQ        10'h253
`define ALX_OP_WAKE_A     10'h256
`define ALX_OP_WAKE_B     10'h259
`define ALX_OP_WAKE_C     10'h25A
`define ALX_OP_WAKE_D     10'h25B
`define ALX_OP_LCD        10'h24A
`define ALX_OP_RAM        10'h2C0
`define ALX_OP_RAM_MASK   10'h3F0
`define ALX_IMM_HI        3
`define ALX_IMM_LO        0

// ----------------------------------------------------------------
// Fields, sizes and reset values
// ----------------------------------------------------------------
`define ALX_NIB_W         4
`define ALX_PTR_W         3
`define ALX_DATA_PTR_W    9
`define ALX_RAM_DEPTH     288
`define ALX_ST_CARRY      0
`define ALX_ST_SKIP       1
`define ALX_ST_UNKNOWN    2
`define ALX_RST_NIB       4'h0
`define ALX_RST_PTR       3'h0
`define ALX_RST_DATA_PTR  9'h000
`define ALX_RST_OP        10'h000

`endif

//--- logic/alx_pkg.sv
// Purpose: Types shared by the accumulator load block
// Assumes: alx_map.svh included where offsets are needed
// Notes:   Types only
package alx_pkg;

  // ----------------------------------------------------------------
  // Instruction classes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ALX_CLS_NONE,
    ALX_CLS_PTR,
    ALX_CLS_IRQ,
    ALX_CLS_WAKE_A,
    ALX_CLS_WAKE_B,
    ALX_CLS_WAKE_C,
    ALX_CLS_WAKE_D,
    ALX_CLS_LCD,
    ALX_CLS_RAM
  } alx_cls_type;

  // ----------------------------------------------------------------
  // Core state carried together
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] xreg;
    logic       carry;
    logic       skip;
    logic       unknown;
  } alx_core_type;

  typedef struct packed {
    logic [3:0] irq_ctrl_reg;
    logic [3:0] wake_ctrl_a;
    logic [3:0] wake_ctrl_b;
    logic [3:0] wake_ctrl_c;
    logic [3:0] wake_ctrl_d;
    logic [3:0] lcd_ctrl_reg;
    logic [2:0] pointer_reg_bits;
    logic [8:0] data_pointer;
  } alx_ctrl_type;

endpackage

//--- logic/alx_ram.sv
// Purpose: Nibble-wide data memory with registered read
// Assumes: Single clock, one write port, one read port
// Notes:   Addresses beyond the depth read zero
`timescale 1ns/1ps
`include "alx_map.svh"

module alx_ram (
  // Clock
  input  wire logic                        aclk,
  // Write port
  input  wire logic                        wr_en,
  input  wire logic [`ALX_DATA_PTR_W-1:0]  wr_addr,
  input  wire logic [`ALX_NIB_W-1:0]       wr_data,
  // Read port
  input  wire logic [`ALX_DATA_PTR_W-1:0]  rd_addr,
  output logic      [`ALX_NIB_W-1:0]       rd_data
);

  logic [`ALX_NIB_W-1:0] mem [0:`ALX_RAM_DEPTH-1];
  wire                   wr_ok = wr_en && (wr_addr < `ALX_DATA_PTR_W'(`ALX_RAM_DEPTH));
  wire                   rd_ok = rd_addr < `ALX_DATA_PTR_W'(`ALX_RAM_DEPTH);

  always_ff @(posedge aclk) begin
    if (wr_ok) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    rd_data <= rd_ok ? mem[rd_addr] : `ALX_RST_NIB;
  end

endmodule // alx_ram

//--- logic/alx_decoder.sv
// Purpose: Decode and run the accumulator load instructions
// Assumes: Software issues opcodes and loads sources over AXI4-Lite
// Notes:   One instruction per write to the instruction register
`timescale 1ns/1ps
`include "alx_map.svh"

module alx_decoder (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Write address channel
  input  wire logic [`ALX_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]            awprot,
  input  wire logic                  awvalid,
  output logic                       awready,
  // Write data channel
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  // Write response channel
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // Read address channel
  input  wire logic [`ALX_ADDR_W-1:0] araddr,
  input  wire logic [2:0]            arprot,
  input  wire logic                  arvalid,
  output logic                       arready,
  // Read data channel
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // Core state
  output logic [3:0]                 acc_out,
  output logic [3:0]                 xreg_out,
  output logic                       carry_flag,
  output logic                       skip_next
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic alx_pkg::alx_cls_type classify(input logic [`ALX_OP_W-1:0] op);
    alx_pkg::alx_cls_type c;
    c = alx_pkg::ALX_CLS_NONE;
    case (op)
      `ALX_OP_PTR:    c = alx_pkg::ALX_CLS_PTR;
      `ALX_OP_IRQ:    c = alx_pkg::ALX_CLS_IRQ;
      `ALX_OP_WAKE_A: c = alx_pkg::ALX_CLS_WAKE_A;
      `ALX_OP_WAKE_B: c = alx_pkg::ALX_CLS_WAKE_B;
      `ALX_OP_WAKE_C: c = alx_pkg::ALX_CLS_WAKE_C;
      `ALX_OP_WAKE_D: c = alx_pkg::ALX_CLS_WAKE_D;
      `ALX_OP_LCD:    c = alx_pkg::ALX_CLS_LCD;
      default: begin
        if ((op & `ALX_OP_RAM_MASK) == `ALX_OP_RAM) begin
          c = alx_pkg::ALX_CLS_RAM;
        end
      end
    endcase
    return c;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  alx_pkg::alx_core_type   core;
  alx_pkg::alx_ctrl_type   ctrl;
  logic [`ALX_OP_W-1:0]    last_op;
  logic [`ALX_ADDR_W-1:0]  aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    aw_held;
  logic                    w_held;
  logic [`ALX_NIB_W-1:0]   ram_rd;

  // ----------------------------------------------------------------
  // Write path decode
  // ----------------------------------------------------------------
  wire        do_write   = aw_held && w_held && !bvalid;
  wire        wr_instr   = do_write && (aw_addr == `ALX_OFF_INSTR);
  wire        wr_acc     = do_write && (aw_addr == `ALX_OFF_ACC);
  wire        wr_xreg    = do_write && (aw_addr == `ALX_OFF_XREG);
  wire        wr_ptr     = do_write && (aw_addr == `ALX_OFF_PTR);
  wire        wr_irq     = do_write && (aw_addr == `ALX_OFF_IRQ);
  wire        wr_wake_a  = do_write && (aw_addr == `ALX_OFF_WAKE_A);
  wire        wr_wake_b  = do_write && (aw_addr == `ALX_OFF_WAKE_B);
  wire        wr_wake_c  = do_write && (aw_addr == `ALX_OFF_WAKE_C);
  wire        wr_wake_d  = do_write && (aw_addr == `ALX_OFF_WAKE_D);
  wire        wr_lcd     = do_write && (aw_addr == `ALX_OFF_LCD);
  wire        wr_data_ptr = do_write && (aw_addr == `ALX_OFF_DATA_PTR);
  wire        wr_ram     = do_write && (aw_addr == `ALX_OFF_RAM) && w_strb[0];
  wire        wr_status  = do_write && (aw_addr == `ALX_OFF_STATUS);
  wire        wr_mapped  = wr_instr | wr_acc | wr_xreg | wr_ptr | wr_irq | wr_wake_a | wr_wake_b
                         | wr_wake_c | wr_wake_d | wr_lcd | wr_data_ptr | (aw_addr == `ALX_OFF_RAM) | wr_status;
  wire [31:0] wr_word    = merge(32'h0000_0000, w_data, w_strb);
  wire [31:0] op_word    = merge({22'h00_0000, last_op}, w_data, w_strb);
  wire [31:0] ptr_word   = merge({23'h00_0000, ctrl.data_pointer}, w_data, w_strb);

  // ----------------------------------------------------------------
  // Instruction execution
  // ----------------------------------------------------------------
  wire                       exec    = wr_instr;
  wire [`ALX_OP_W-1:0]       exec_op = op_word[`ALX_OP_W-1:0];
  alx_pkg::alx_cls_type      exec_cls;
  assign exec_cls = exec ? classify(exec_op) : alx_pkg::ALX_CLS_NONE;
  wire [3:0]                 imm     = exec_op[`ALX_IMM_HI:`ALX_IMM_LO];

  alx_pkg::alx_core_type next_core;
  always_comb begin
    next_core = core;
    case (exec_cls)
      alx_pkg::ALX_CLS_PTR:    next_core.acc = {1'b0, ctrl.pointer_reg_bits};
      alx_pkg::ALX_CLS_IRQ:    next_core.acc = ctrl.irq_ctrl_reg;
      alx_pkg::ALX_CLS_WAKE_A: next_core.acc = ctrl.wake_ctrl_a;
      alx_pkg::ALX_CLS_WAKE_B: next_core.acc = ctrl.wake_ctrl_b;
      alx_pkg::ALX_CLS_WAKE_C: next_core.acc = ctrl.wake_ctrl_c;
      alx_pkg::ALX_CLS_WAKE_D: next_core.acc = ctrl.wake_ctrl_d;
      alx_pkg::ALX_CLS_LCD:    next_core.acc = ctrl.lcd_ctrl_reg;
      alx_pkg::ALX_CLS_RAM: begin
        next_core.acc  = ram_rd;
        next_core.xreg = core.xreg ^ imm;
      end
      default: begin
        next_core.unknown = core.unknown | exec;
      end
    endcase
    // Carry and skip follow software only
    if (wr_acc) begin
      next_core.acc = wr_word[3:0];
    end
    if (wr_xreg) begin
      next_core.xreg = wr_word[3:0];
    end
    if (wr_status) begin
      next_core.carry   = wr_word[`ALX_ST_CARRY];
      next_core.skip    = wr_word[`ALX_ST_SKIP];
      next_core.unknown = next_core.unknown & ~wr_word[`ALX_ST_UNKNOWN];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core    <= '0;
      last_op <= `ALX_RST_OP;
    end else begin
      core    <= next_core;
      last_op <= exec ? exec_op : last_op;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= '0;
    end else begin
      if (wr_ptr)    ctrl.pointer_reg_bits <= wr_word[`ALX_PTR_W-1:0];
      if (wr_irq)    ctrl.irq_ctrl_reg     <= wr_word[3:0];
      if (wr_wake_a) ctrl.wake_ctrl_a      <= wr_word[3:0];
      if (wr_wake_b) ctrl.wake_ctrl_b      <= wr_word[3:0];
      if (wr_wake_c) ctrl.wake_ctrl_c      <= wr_word[3:0];
      if (wr_wake_d) ctrl.wake_ctrl_d      <= wr_word[3:0];
      if (wr_lcd)    ctrl.lcd_ctrl_reg     <= wr_word[3:0];
      if (wr_data_ptr) ctrl.data_pointer   <= ptr_word[`ALX_DATA_PTR_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------------
  alx_ram u_ram (
    .aclk    (aclk),
    .wr_en   (wr_ram),
    .wr_addr (ctrl.data_pointer),
    .wr_data (w_data[3:0]),
    .rd_addr (ctrl.data_pointer),
    .rd_data (ram_rd)
  );

  // ----------------------------------------------------------------
  // AXI write channels
  // ----------------------------------------------------------------
  assign awready = !aw_held;
  assign wready  = !w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= `ALX_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= {awaddr[`ALX_ADDR_W-1:2], 2'h0};
      end else if (bvalid && bready) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (bvalid && bready) begin
        w_held <= 1'b0;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= wr_mapped ? `ALX_RESP_OKAY : `ALX_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI read channels
  // ----------------------------------------------------------------
  wire [`ALX_ADDR_W-1:0] ra = {araddr[`ALX_ADDR_W-1:2], 2'h0};
  logic [31:0]           rd_word;
  logic                  rd_hit;
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (ra)
      `ALX_OFF_INSTR:  rd_word[`ALX_OP_W-1:0]  = last_op;
      `ALX_OFF_ACC:    rd_word[3:0]            = core.acc;
      `ALX_OFF_XREG:   rd_word[3:0]            = core.xreg;
      `ALX_OFF_PTR:    rd_word[`ALX_PTR_W-1:0] = ctrl.pointer_reg_bits;
      `ALX_OFF_IRQ:    rd_word[3:0]            = ctrl.irq_ctrl_reg;
      `ALX_OFF_WAKE_A: rd_word[3:0]            = ctrl.wake_ctrl_a;
      `ALX_OFF_WAKE_B: rd_word[3:0]            = ctrl.wake_ctrl_b;
      `ALX_OFF_WAKE_C: rd_word[3:0]            = ctrl.wake_ctrl_c;
      `ALX_OFF_WAKE_D: rd_word[3:0]            = ctrl.wake_ctrl_d;
      `ALX_OFF_LCD:    rd_word[3:0]            = ctrl.lcd_ctrl_reg;
      `ALX_OFF_DATA_PTR: rd_word[`ALX_DATA_PTR_W-1:0] = ctrl.data_pointer;
      `ALX_OFF_RAM:    rd_word[3:0]            = ram_rd;
      `ALX_OFF_STATUS: rd_word[2:0]            = {core.unknown, core.skip, core.carry};
      default:         rd_hit                  = 1'b0;
    endcase
  end

  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `ALX_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_hit ? `ALX_RESP_OKAY : `ALX_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  assign acc_out    = core.acc;
  assign xreg_out   = core.xreg;
  assign carry_flag = core.carry;
  assign skip_next  = core.skip;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ptr_load: assert property (exec_cls == alx_pkg::ALX_CLS_PTR |=>
    acc_out == {1'b0, $past(ctrl.pointer_reg_bits)}) else $error("pointer load wrong");
  a_irq_load: assert property (exec && exec_op == `ALX_OP_IRQ |=>
    acc_out == $past(ctrl.irq_ctrl_reg)) else $error("irq control load wrong");
  a_wake_a_load: assert property (exec && exec_op == `ALX_OP_WAKE_A |=>
    acc_out == $past(ctrl.wake_ctrl_a)) else $error("wakeup a load wrong");
  a_wake_b_load: assert property (exec && exec_op == `ALX_OP_WAKE_B |=>
    acc_out == $past(ctrl.wake_ctrl_b)) else $error("wakeup b load wrong");
  a_wake_c_load: assert property (exec_cls == alx_pkg::ALX_CLS_WAKE_C |=>
    acc_out == $past(ctrl.wake_ctrl_c)) else $error("wakeup c load wrong");
  a_wake_d_load: assert property (exec && exec_op == `ALX_OP_WAKE_D |=>
    acc_out == $past(ctrl.wake_ctrl_d)) else $error("wakeup d load wrong");
  a_lcd_load: assert property (exec_cls == alx_pkg::ALX_CLS_LCD |=>
    acc_out == $past(ctrl.lcd_ctrl_reg)) else $error("lcd load wrong");
  a_ram_load: assert property (exec && (exec_op & `ALX_OP_RAM_MASK) == `ALX_OP_RAM |=>
    acc_out == $past(ram_rd)) else $error("ram load wrong");
  a_xor_update: assert property (exec_cls == alx_pkg::ALX_CLS_RAM |=>
    xreg_out == ($past(xreg_out) ^ $past(imm))) else $error("x xor wrong");
  a_flags_kept: assert property (exec |=> $stable(carry_flag) && $stable(skip_next))
    else $error("load changed carry or skip");
  a_resp_timing: assert property (aw_held && w_held && !bvalid |=> bvalid ##0 $stable(aw_held))
    else $error("write response late");

  c_ram_load: cover property (exec_cls == alx_pkg::ALX_CLS_RAM);
  c_ptr_load: cover property (exec_cls == alx_pkg::ALX_CLS_PTR);
  c_back_to_back: cover property (exec ##[1:8] exec);
  c_bad_read: cover property (rvalid && rresp == `ALX_RESP_SLVERR);

endmodule // alx_decoder

//--- bench/accumulator_load_instructions_tb.sv
// Purpose: Self-checking bench for the accumulator load instructions
// Assumes: AXI4-Lite master tasks, 250 MHz aclk, synchronous active-low reset
// Notes:   Sources loaded over the bus, then each opcode executed and judged
`timescale 1ns/1ps
`include "alx_map.svh"

module accumulator_load_instructions_tb;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [3:0]  acc_out;
  logic [3:0]  xreg_out;
  logic        carry_flag;
  logic        skip_next;
  int          err_count;
  int          tests_run;
  int          cycles;

  // ----------------------------------------------------------------
  // Clock, timeout and design
  // ----------------------------------------------------------------
  initial aclk = 1'b0;
  always #2 aclk = ~aclk;

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      give_verdict();
    end
  end

  alx_decoder i_alx_decoder (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .awaddr     (awaddr),
    .awprot     (3'h0),
    .awvalid    (awvalid),
    .awready    (awready),
    .wdata      (wdata),
    .wstrb      (wstrb),
    .wvalid     (wvalid),
    .wready     (wready),
    .bresp      (bresp),
    .bvalid     (bvalid),
    .bready     (bready),
    .araddr     (araddr),
    .arprot     (3'h0),
    .arvalid    (arvalid),
    .arready    (arready),
    .rdata      (rdata),
    .rresp      (rresp),
    .rvalid     (rvalid),
    .rready     (rready),
    .acc_out    (acc_out),
    .xreg_out   (xreg_out),
    .carry_flag (carry_flag),
    .skip_next  (skip_next)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check({30'h0, r}, {30'h0, `ALX_RESP_OKAY}, "write response");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_sources();
    logic [7:0] offs [6];
    logic [9:0] ops [6];
    logic [3:0] vals [6];
    offs = '{`ALX_OFF_IRQ, `ALX_OFF_WAKE_A, `ALX_OFF_WAKE_B, `ALX_OFF_WAKE_C, `ALX_OFF_WAKE_D, `ALX_OFF_LCD};
    ops = '{`ALX_OP_IRQ, `ALX_OP_WAKE_A, `ALX_OP_WAKE_B, `ALX_OP_WAKE_C, `ALX_OP_WAKE_D, `ALX_OP_LCD};
    vals = '{4'h3, 4'h5, 4'h6, 4'h9, 4'hA, 4'hC};
    wr(`ALX_OFF_STATUS, 32'h3);
    for (int i = 0; i < 6; i++) begin
      wr(offs[i], {28'h0, vals[i]});
    end
    for (int i = 0; i < 6; i++) begin
      wr(`ALX_OFF_INSTR, {22'h0, ops[i]});
      check({28'h0, acc_out}, {28'h0, vals[i]}, "source load");
      check({30'h0, carry_flag, skip_next}, 32'h3, "flags kept");
    end
  endtask

  task automatic t_pointer();
    wr(`ALX_OFF_PTR, 32'hF);
    wr(`ALX_OFF_INSTR, {22'h0, `ALX_OP_PTR});
    check({28'h0, acc_out}, 32'h7, "pointer load top bit");
    wr(`ALX_OFF_PTR, 32'h2);
    wr(`ALX_OFF_INSTR, {22'h0, `ALX_OP_PTR});
    check({28'h0, acc_out}, 32'h2, "pointer load value");
    check({30'h0, carry_flag, skip_next}, 32'h3, "flags kept");
  endtask

  task automatic t_ram();
    wr(`ALX_OFF_XREG, 32'h5);
    wr(`ALX_OFF_DATA_PTR, 32'h11F);
    wr(`ALX_OFF_RAM, 32'hA);
    wr(`ALX_OFF_DATA_PTR, 32'h000);
    wr(`ALX_OFF_RAM, 32'h3);
    wr(`ALX_OFF_DATA_PTR, 32'h11F);
    wr(`ALX_OFF_INSTR, {22'h0, `ALX_OP_RAM | 10'h00F});
    check({28'h0, acc_out}, 32'hA, "ram load top address");
    check({28'h0, xreg_out}, 32'hA, "x xor fifteen");
    wr(`ALX_OFF_DATA_PTR, 32'h000);
    wr(`ALX_OFF_INSTR, {22'h0, `ALX_OP_RAM});
    check({28'h0, acc_out}, 32'h3, "ram load address zero");
    check({28'h0, xreg_out}, 32'hA, "x xor zero");
    wr(`ALX_OFF_INSTR, {22'h0, `ALX_OP_RAM | 10'h006});
    check({28'h0, acc_out}, 32'h3, "ram load repeat");
    check({28'h0, xreg_out}, 32'hC, "x xor six");
    check({30'h0, carry_flag, skip_next}, 32'h3, "flags kept");
  endtask

  task automatic t_bus_misc();
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(8'h40, d, r);
    check({30'h0, r}, {30'h0, `ALX_RESP_SLVERR}, "unmapped read resp");
    check(d, 32'h0, "unmapped read data");
    axi_write(8'h44, 32'h5, r);
    check({30'h0, r}, {30'h0, `ALX_RESP_SLVERR}, "unmapped write resp");
    wr(`ALX_OFF_INSTR, 32'h3FF);
    check({28'h0, acc_out}, 32'h3, "unknown opcode leaves acc");
    axi_read(`ALX_OFF_STATUS, d, r);
    check(d, 32'h7, "unknown opcode status");
    wr(`ALX_OFF_STATUS, 32'h7);
    axi_read(`ALX_OFF_STATUS, d, r);
    check(d, 32'h3, "sticky cleared");
    axi_read(`ALX_OFF_INSTR, d, r);
    check(d, 32'h3FF, "last opcode readback");
    wr(`ALX_OFF_ACC, 32'h9);
    check({28'h0, acc_out}, 32'h9, "acc write");
    wr(`ALX_OFF_DATA_PTR, 32'h120);
    wr(`ALX_OFF_RAM, 32'h5);
    axi_read(`ALX_OFF_RAM, d, r);
    check(d, 32'h0, "ram beyond depth");
    wr(`ALX_OFF_INSTR, {22'h0, `ALX_OP_RAM});
    check({28'h0, acc_out}, 32'h0, "ram load beyond depth");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    err_count = 0;
    tests_run = 0;
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({24'h0, acc_out, xreg_out}, 32'h0, "reset state");
    check({30'h0, carry_flag, skip_next}, 32'h0, "reset flags");
    t_sources();
    t_pointer();
    t_ram();
    t_bus_misc();
    give_verdict();
  end

endmodule // accumulator_load_instructions_tb
